// ---- inc/fdsi_defs.svh ----
// Register offsets, field positions and reset values of the drive signal block
`ifndef FDSI_DEFS_SVH
`define FDSI_DEFS_SVH

// Register byte offsets
`define FDSI_OFS_DOR     8'h00
`define FDSI_OFS_CCR     8'h04
`define FDSI_OFS_DSR     8'h08
`define FDSI_OFS_CFG     8'h0c
`define FDSI_OFS_DIN     8'h10
`define FDSI_OFS_MODE    8'h14
`define FDSI_OFS_OPCTL   8'h18
`define FDSI_OFS_IDXCNT  8'h1c
`define FDSI_OFS_STATUS  8'h20

// Digital output register fields
`define FDSI_DOR_SEL_LSB   0
`define FDSI_DOR_MOT_LSB   4

// Configuration register fields
`define FDSI_CFG_OR0       0
`define FDSI_CFG_OR1       1
`define FDSI_CFG_ALT0      2
`define FDSI_CFG_ALT1      3
`define FDSI_CFG_DPOL      5
`define FDSI_CFG_FOUR      7

// Digital input, mode, operation control and status fields
`define FDSI_DIN_INDEX     0
`define FDSI_DIN_CHG       7
`define FDSI_MODE_READ_GATE_DIAG_IN    0
`define FDSI_OP_LSB        0
`define FDSI_OP_STEPIN     2
`define FDSI_OP_SIDE1      3
`define FDSI_ST_READ_GATE_DIAG_IN      0
`define FDSI_ST_OP_LSB     1

// Reset values
`define FDSI_RST_DOR       8'h00
`define FDSI_RST_RATE      2'h0
`define FDSI_RST_CFG       8'h00
`define FDSI_RST_MODE      8'h00
`define FDSI_RST_OPCTL     8'h00

// Data rate codes
`define FDSI_RATE_500K     2'h0
`define FDSI_RATE_300K     2'h1
`define FDSI_RATE_250K     2'h2
`define FDSI_RATE_1M       2'h3

// Synchroniser depth
`define FDSI_SYNC_STAGES   2

`endif

// ---- inc/fdsi_pkg.sv ----
// Types shared by the drive signal block
package fdsi_pkg;

  // Current drive operation, Gray coded along idle-seek-read-write
  typedef enum logic [1:0] {
    FDSI_OP_IDLE  = 2'h0,
    FDSI_OP_SEEK  = 2'h1,
    FDSI_OP_READ  = 2'h3,
    FDSI_OP_WRITE = 2'h2
  } fdsi_op_e;

  // Pins driven toward the drives
  typedef struct packed {
    logic dens;
    logic ds0_n;
    logic ds1_n;
    logic mot0_n;
    logic mot1_n;
    logic rate0;
    logic step_in_n;
    logic side_n;
  } fdsi_drive_s;

  // Pins sampled from the drives
  typedef struct packed {
    logic chg;
    logic index_n;
  } fdsi_sense_s;

  typedef logic [7:0] fdsi_byte_t;

endpackage

// ---- logic/fdsi_sync.sv ----
// Two-stage synchroniser for pins sampled from the drives
`timescale 1ns/10ps
module fdsi_sync #(
  parameter int         W       = 2,
  parameter logic [1:0] RST_VAL = 2'h0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage is read by the second stage only
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= W'(RST_VAL);
      q      <= W'(RST_VAL);
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// ---- logic/fdsi_top.sv ----
// Drive-side signal block of a floppy controller with APB registers
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "fdsi_defs.svh"
//
// Overview of operation
// - Density output active at 500K or 1M
// - Configuration bit 5 sets density polarity
// - Seek: direction active inward, inactive outward
// - Direction inactive during any read or write
// - Drive selects decoded from output register bits
// - Configuration bit 7 encodes four drives
// - Select 0 ORed with motor 0 optionally
// - Select 1 ORed with motor 1 optionally
// - Rate bit from last written rate register
// - Disk change sampled, readable in input register
// - Mode bit repurposes disk change as read gate
// - Side select low picks side 1
module fdsi_top (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Drive pins, sampled
  input  wire logic        DISK_CHANGE_IN,
  input  wire logic        INDEX_N,
  // Drive pins, driven
  output logic             DENSITY_SELECT_OUT,
  output logic             DRIVE_SELECT_0_N,
  output logic             DRIVE_SELECT_1_N,
  output logic             MOTOR_ON_0_N,
  output logic             MOTOR_ON_1_N,
  output logic             RATE_BIT0_OUT,
  output logic             HEAD_STEP_IN_N,
  output logic             HEAD_SIDE_SELECT_OUT
);

  // Register state
  fdsi_pkg::fdsi_byte_t  digital_output_reg_r;
  fdsi_pkg::fdsi_byte_t  cfg_r;
  fdsi_pkg::fdsi_byte_t  mode_r;
  fdsi_pkg::fdsi_byte_t  opctl_r;
  fdsi_pkg::fdsi_byte_t  idx_cnt_r;
  logic [1:0]            rate_r;
  logic [1:0]            dsr_rate_r;
  logic [1:0]            ccr_rate_r;

  // Bus decode
  logic                  setup;
  logic                  wr_en;
  logic                  addr_ok;
  fdsi_pkg::fdsi_byte_t  rd_byte;
  fdsi_pkg::fdsi_byte_t  wr_byte;

  // Sampled pins
  fdsi_pkg::fdsi_sense_s sense_raw;
  fdsi_pkg::fdsi_sense_s sense;
  logic                  index_prev_r;
  logic                  index_fall;

  // Derived drive values
  fdsi_pkg::fdsi_op_e    op;
  fdsi_pkg::fdsi_drive_s drv_nxt;
  fdsi_pkg::fdsi_drive_s drv_r;
  logic                  high_rate;
  logic                  sel_motor_on;
  logic [1:0]            dec_n;
  logic [1:0]            enc_n;
  logic                  read_gate_diag_in_sel;
  logic                  chg_vis;
  logic                  read_gate_diag_in_vis;

  assign setup   = PSEL & ~PENABLE;
  // A write lands on the access edge at which PREADY is seen high
  assign wr_en   = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
  assign wr_byte = PWDATA[7:0];

  always_comb begin
    addr_ok = 1'b1;
    case (PADDR)
      `FDSI_OFS_DOR,
      `FDSI_OFS_CCR,
      `FDSI_OFS_DSR,
      `FDSI_OFS_CFG,
      `FDSI_OFS_DIN,
      `FDSI_OFS_MODE,
      `FDSI_OFS_OPCTL,
      `FDSI_OFS_IDXCNT,
      `FDSI_OFS_STATUS: addr_ok = 1'b1;
      default:          addr_ok = 1'b0;
    endcase
  end

  // Disk change and index come from the drive cable, unrelated timing
  assign sense_raw.chg     = DISK_CHANGE_IN;
  assign sense_raw.index_n = INDEX_N;

  fdsi_sync #(
    .W       (2),
    .RST_VAL (2'h1)
  ) u_sync (
    .clk (MCLK),
    .rst (RST),
    .d   (sense_raw),
    .q   (sense)
  );

  // Read gate mode steals the disk change pin
  assign read_gate_diag_in_sel = mode_r[`FDSI_MODE_READ_GATE_DIAG_IN];
  assign chg_vis   = read_gate_diag_in_sel ? 1'b0 : sense.chg;
  assign read_gate_diag_in_vis = read_gate_diag_in_sel ? sense.chg : 1'b0;

  // Read data mux
  always_comb begin
    rd_byte = 8'h00;
    case (PADDR)
      `FDSI_OFS_DOR:    rd_byte = digital_output_reg_r;
      `FDSI_OFS_CCR:    rd_byte = {6'h00, ccr_rate_r};
      `FDSI_OFS_DSR:    rd_byte = {6'h00, dsr_rate_r};
      `FDSI_OFS_CFG:    rd_byte = cfg_r;
      `FDSI_OFS_DIN: begin
        rd_byte[`FDSI_DIN_CHG]   = chg_vis;
        rd_byte[`FDSI_DIN_INDEX] = ~sense.index_n;
      end
      `FDSI_OFS_MODE:   rd_byte = mode_r;
      `FDSI_OFS_OPCTL:  rd_byte = opctl_r;
      `FDSI_OFS_IDXCNT: rd_byte = idx_cnt_r;
      `FDSI_OFS_STATUS: begin
        rd_byte[`FDSI_ST_READ_GATE_DIAG_IN]                    = read_gate_diag_in_vis;
        rd_byte[`FDSI_ST_OP_LSB+1:`FDSI_ST_OP_LSB] = op;
      end
      default:          rd_byte = 8'h00;
    endcase
  end

  // Zero-wait slave: answer is ready in the first access cycle
  always_ff @(posedge MCLK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY <= setup;
      if (setup) begin
        PSLVERR <= ~addr_ok;
        PRDATA  <= (PWRITE | ~addr_ok) ? 32'h0000_0000
                                       : {24'h00_0000, rd_byte};
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // Digital output register
  always_ff @(posedge MCLK) begin
    if (RST) begin
      digital_output_reg_r <= `FDSI_RST_DOR;
    end else if (wr_en && PADDR == `FDSI_OFS_DOR) begin
      digital_output_reg_r <= wr_byte;
    end
  end

  // Both rate registers feed one rate; the later write wins
  always_ff @(posedge MCLK) begin
    if (RST) begin
      rate_r     <= `FDSI_RST_RATE;
      ccr_rate_r <= `FDSI_RST_RATE;
      dsr_rate_r <= `FDSI_RST_RATE;
    end else if (wr_en && PADDR == `FDSI_OFS_CCR) begin
      ccr_rate_r <= wr_byte[1:0];
      rate_r     <= wr_byte[1:0];
    end else if (wr_en && PADDR == `FDSI_OFS_DSR) begin
      dsr_rate_r <= wr_byte[1:0];
      rate_r     <= wr_byte[1:0];
    end
  end

  // Configuration register
  always_ff @(posedge MCLK) begin
    if (RST) begin
      cfg_r <= `FDSI_RST_CFG;
    end else if (wr_en && PADDR == `FDSI_OFS_CFG) begin
      cfg_r <= wr_byte;
    end
  end

  // Mode register
  always_ff @(posedge MCLK) begin
    if (RST) begin
      mode_r <= `FDSI_RST_MODE;
    end else if (wr_en && PADDR == `FDSI_OFS_MODE) begin
      mode_r <= wr_byte;
    end
  end

  // Operation control register
  always_ff @(posedge MCLK) begin
    if (RST) begin
      opctl_r <= `FDSI_RST_OPCTL;
    end else if (wr_en && PADDR == `FDSI_OFS_OPCTL) begin
      opctl_r <= wr_byte;
    end
  end

  assign op = fdsi_pkg::fdsi_op_e'(opctl_r[`FDSI_OP_LSB+1:`FDSI_OP_LSB]);

  // Index falling edge, seen on the synchronised copy only
  always_ff @(posedge MCLK) begin
    if (RST) begin
      index_prev_r <= 1'b1;
    end else begin
      index_prev_r <= sense.index_n;
    end
  end

  assign index_fall = index_prev_r & ~sense.index_n;

  // Revolution counter; a pulse in the same cycle as a clearing write leaves a count of 1
  always_ff @(posedge MCLK) begin
    if (RST) begin
      idx_cnt_r <= 8'h00;
    end else if (index_fall) begin
      if (wr_en && PADDR == `FDSI_OFS_IDXCNT) begin
        idx_cnt_r <= 8'h01;
      end else begin
        idx_cnt_r <= idx_cnt_r + 8'h01;
      end
    end else if (wr_en && PADDR == `FDSI_OFS_IDXCNT) begin
      idx_cnt_r <= 8'h00;
    end
  end

  // Density follows rate class, polarity from configuration
  assign high_rate = (rate_r == `FDSI_RATE_500K) ||
                     (rate_r == `FDSI_RATE_1M);

  // In four-drive mode the selected drive counts as selected only while its motor is enabled
  assign sel_motor_on =
    digital_output_reg_r[`FDSI_DOR_MOT_LSB +
                         32'(digital_output_reg_r[1:0])];

  // Plain decode reaches drives 0 and 1 only
  always_comb begin
    dec_n = 2'h3;
    case (digital_output_reg_r[`FDSI_DOR_SEL_LSB+1:`FDSI_DOR_SEL_LSB])
      2'h0:    dec_n = 2'h2;
      2'h1:    dec_n = 2'h1;
      default: dec_n = 2'h3;
    endcase
  end

  // Encoded pins drive an external decoder; drive 0 and none share
  // the idle code, so that decoder must also watch the motor lines
  assign enc_n = sel_motor_on ?
                 ~digital_output_reg_r[1:0] : 2'h3;

  always_comb begin
    drv_nxt = '0;
    // Polarity bit set means active high
    drv_nxt.dens = cfg_r[`FDSI_CFG_DPOL] ? high_rate
                                         : ~high_rate;
    if (cfg_r[`FDSI_CFG_FOUR]) begin
      drv_nxt.ds0_n = enc_n[0];
      drv_nxt.ds1_n = enc_n[1];
    end else begin
      drv_nxt.ds0_n = dec_n[0];
      drv_nxt.ds1_n = dec_n[1];
    end
    drv_nxt.mot0_n = ~digital_output_reg_r[`FDSI_DOR_MOT_LSB];
    drv_nxt.mot1_n = ~digital_output_reg_r[`FDSI_DOR_MOT_LSB+1];
    // Reassigned motor pins rest inactive; the select may carry motor
    if (cfg_r[`FDSI_CFG_ALT0]) begin
      drv_nxt.mot0_n = 1'b1;
      if (cfg_r[`FDSI_CFG_OR0]) begin
        drv_nxt.ds0_n = drv_nxt.ds0_n &
                        ~digital_output_reg_r[`FDSI_DOR_MOT_LSB];
      end
    end
    if (cfg_r[`FDSI_CFG_ALT1]) begin
      drv_nxt.mot1_n = 1'b1;
      if (cfg_r[`FDSI_CFG_OR1]) begin
        drv_nxt.ds1_n = drv_nxt.ds1_n &
                        ~digital_output_reg_r[`FDSI_DOR_MOT_LSB+1];
      end
    end
    drv_nxt.rate0 = rate_r[0];
    // Direction only asserted while seeking inward
    case (op)
      fdsi_pkg::FDSI_OP_SEEK:
        drv_nxt.step_in_n = ~opctl_r[`FDSI_OP_STEPIN];
      fdsi_pkg::FDSI_OP_READ,
      fdsi_pkg::FDSI_OP_WRITE:
        drv_nxt.step_in_n = 1'b1;
      default:
        drv_nxt.step_in_n = 1'b1;
    endcase
    drv_nxt.side_n = ~opctl_r[`FDSI_OP_SIDE1];
  end

  // Drive pins all leave one register stage
  always_ff @(posedge MCLK) begin
    if (RST) begin
      drv_r <= '{dens: 1'b0, ds0_n: 1'b1, ds1_n: 1'b1, mot0_n: 1'b1,
                 mot1_n: 1'b1, rate0: 1'b0, step_in_n: 1'b1,
                 side_n: 1'b1};
    end else begin
      drv_r <= drv_nxt;
    end
  end

  assign DENSITY_SELECT_OUT   = drv_r.dens;
  assign DRIVE_SELECT_0_N     = drv_r.ds0_n;
  assign DRIVE_SELECT_1_N     = drv_r.ds1_n;
  assign MOTOR_ON_0_N         = drv_r.mot0_n;
  assign MOTOR_ON_1_N         = drv_r.mot1_n;
  assign RATE_BIT0_OUT        = drv_r.rate0;
  assign HEAD_STEP_IN_N       = drv_r.step_in_n;
  assign HEAD_SIDE_SELECT_OUT = drv_r.side_n;

endmodule

// ---- verif/fdsi_drive_model.sv ----
// Behavioural floppy drive driving the sensed pins
`timescale 1ns/10ps
module fdsi_drive_model (
  // Clock
  input wire logic mclk,
  // Pins toward the controller
  output logic     chg,
  output logic     index_n
);
  initial begin
    chg = 1'b0;
    index_n = 1'b1;
  end
  // Door level held until told otherwise
  task automatic set_change(input logic v);
    @(posedge mclk);
    chg <= v;
  endtask
  // Short pulses keep the run brief; real tracks are far longer
  task automatic pulse_index(input int n);
    repeat (n) begin
      @(posedge mclk);
      index_n <= 1'b0;
      repeat (4) @(posedge mclk);
      index_n <= 1'b1;
      repeat (8) @(posedge mclk);
    end
  endtask
endmodule

// ---- verif/fdsi_top_props.sv ----
// Port checker for the drive signal block
`timescale 1ns/10ps
`include "fdsi_defs.svh"
module fdsi_top_props (
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RST,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Drive pins
  input wire logic        DENSITY_SELECT_OUT,
  input wire logic        DRIVE_SELECT_0_N,
  input wire logic        DRIVE_SELECT_1_N,
  input wire logic        MOTOR_ON_0_N,
  input wire logic        MOTOR_ON_1_N,
  input wire logic        RATE_BIT0_OUT,
  input wire logic        HEAD_STEP_IN_N,
  input wire logic        HEAD_SIDE_SELECT_OUT
);
  logic [7:0] dor_r, cfg_r, exp_v, exp_r;
  logic [3:0] op_r;
  logic [1:0] rate_r, d, s;
  logic       act;
  // Shadow of what software committed
  always_ff @(posedge MCLK) begin
    if (RST) begin
      dor_r  <= 8'h00;
      cfg_r  <= 8'h00;
      op_r   <= 4'h0;
      rate_r <= 2'h0;
    end else if (PSEL && PENABLE && PREADY && PWRITE && !PSLVERR) begin
      case (PADDR)
        `FDSI_OFS_DOR:   dor_r <= PWDATA[7:0];
        `FDSI_OFS_CFG:   cfg_r <= PWDATA[7:0];
        `FDSI_OFS_CCR,
        `FDSI_OFS_DSR:   rate_r <= PWDATA[1:0];
        `FDSI_OFS_OPCTL: op_r <= PWDATA[3:0];
        default: ;
      endcase
    end
  end
  always_comb begin
    act = (rate_r == 2'h0) || (rate_r == 2'h3);
    d = dor_r[1:0];
    s = cfg_r[7] ? (dor_r[4+d] ? ~d : 2'h3) : {d != 2'h1, d != 2'h0};
    s[0] = s[0] & ~(cfg_r[0] & cfg_r[2] & dor_r[4]);
    s[1] = s[1] & ~(cfg_r[1] & cfg_r[3] & dor_r[5]);
    exp_v = {cfg_r[5] ~^ act, s[0], s[1], cfg_r[2] | ~dor_r[4],
             cfg_r[3] | ~dor_r[5], rate_r[0],
             ~(op_r[1:0] == 2'h1 && op_r[2]), ~op_r[3]};
  end
  // Pins lag the committed state by one edge; reset pins deselect all
  always_ff @(posedge MCLK) begin
    if (RST) begin
      exp_r <= 8'h7b;
    end else begin
      exp_r <= exp_v;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence setup_s; PSEL && !PENABLE; endsequence
  sequence access_s; PSEL && PENABLE && PREADY; endsequence
  ready_setup_a: assert property (setup_s |=> access_s)
    else $error("no ready after setup");
  ready_pulse_a: assert property (access_s |=> !PREADY)
    else $error("ready longer than one cycle");
  err_unmap_a: assert property (access_s ##0 PADDR > 8'h20 |-> PSLVERR)
    else $error("unmapped access not refused");
  err_map_a: assert property
    (access_s ##0 (PADDR <= 8'h20 && PADDR[1:0] == 2'h0) |-> !PSLVERR)
    else $error("mapped access refused");
  dens_level_a: assert property (DENSITY_SELECT_OUT == exp_r[7])
    else $error("density level wrong");
  sel_decode_a: assert property
    ({DRIVE_SELECT_0_N, DRIVE_SELECT_1_N} == exp_r[6:5])
    else $error("drive selects wrong");
  motor_pins_a: assert property
    ({MOTOR_ON_0_N, MOTOR_ON_1_N} == exp_r[4:3])
    else $error("motor pins wrong");
  rate_bit_a: assert property (RATE_BIT0_OUT == exp_r[2])
    else $error("rate bit wrong");
  step_dir_a: assert property (HEAD_STEP_IN_N == exp_r[1])
    else $error("step direction wrong");
  step_rw_a: assert property ($past(op_r[1]) |-> HEAD_STEP_IN_N)
    else $error("direction active in read or write");
  side_sel_a: assert property (HEAD_SIDE_SELECT_OUT == exp_r[0])
    else $error("side select wrong");
endmodule
bind fdsi_top fdsi_top_props u_props (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR),
  .DENSITY_SELECT_OUT(DENSITY_SELECT_OUT),
  .DRIVE_SELECT_0_N(DRIVE_SELECT_0_N), .DRIVE_SELECT_1_N(DRIVE_SELECT_1_N),
  .MOTOR_ON_0_N(MOTOR_ON_0_N), .MOTOR_ON_1_N(MOTOR_ON_1_N),
  .RATE_BIT0_OUT(RATE_BIT0_OUT), .HEAD_STEP_IN_N(HEAD_STEP_IN_N),
  .HEAD_SIDE_SELECT_OUT(HEAD_SIDE_SELECT_OUT));

// ---- verif/testbench.sv ----
// Self-checking bench for the drive signal block
`timescale 1ns/10ps
`include "fdsi_defs.svh"
module testbench;
  logic        MCLK, RST, PSEL, PENABLE, PWRITE;
  logic [7:0]  PADDR, digital_output_reg, cfg;
  logic [31:0] PWDATA, PRDATA, r;
  logic        PREADY, PSLVERR, chg, idx_n, e;
  logic [7:0]  pin;
  logic [3:0]  op;
  logic [1:0]  rate;
  int          failures, comparisons, cyc;
  logic [7:0]  ra[9] = '{`FDSI_OFS_DOR, `FDSI_OFS_CFG, `FDSI_OFS_DIN,
    `FDSI_OFS_MODE, `FDSI_OFS_OPCTL, `FDSI_OFS_IDXCNT, `FDSI_OFS_STATUS,
    `FDSI_OFS_CCR, `FDSI_OFS_DSR};
  logic [7:0]  wa[5] = '{`FDSI_OFS_DOR, `FDSI_OFS_CFG, `FDSI_OFS_CCR,
    `FDSI_OFS_DSR, `FDSI_OFS_OPCTL};
  fdsi_top uut (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .DISK_CHANGE_IN(chg),
    .INDEX_N(idx_n), .DENSITY_SELECT_OUT(pin[7]),
    .DRIVE_SELECT_0_N(pin[6]), .DRIVE_SELECT_1_N(pin[5]),
    .MOTOR_ON_0_N(pin[4]), .MOTOR_ON_1_N(pin[3]), .RATE_BIT0_OUT(pin[2]),
    .HEAD_STEP_IN_N(pin[1]), .HEAD_SIDE_SELECT_OUT(pin[0]));
  fdsi_drive_model dm (.mclk(MCLK), .chg(chg), .index_n(idx_n));
  always #25 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      failures++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, g);
    comparisons++;
    if (g !== x) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask
  // Expected pin levels from the committed register values
  function automatic logic [7:0] exp_pins();
    logic       a;
    logic [1:0] d, s;
    a = (rate == 2'h0) || (rate == 2'h3);
    d = digital_output_reg[1:0];
    s = cfg[7] ? (digital_output_reg[4+d] ? ~d : 2'h3) : {d != 2'h1, d != 2'h0};
    // Optional select/motor merge on reassigned motor pins
    s[0] = s[0] & !(cfg[0] & cfg[2] & digital_output_reg[4]);
    s[1] = s[1] & !(cfg[1] & cfg[3] & digital_output_reg[5]);
    return {cfg[5] ? a : !a, s[0], s[1], cfg[2] | !digital_output_reg[4],
      cfg[3] | !digital_output_reg[5], rate[0], !(op[1:0] == 2'h1 && op[2]), !op[3]};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] v);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= v;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, x, r);
  endtask
  // Write, track the expected state, then compare all drive pins
  task automatic step(input logic [7:0] a, input logic [7:0] v);
    apb(1'b1, a, {24'h0, v});
    case (a)
      `FDSI_OFS_DOR: digital_output_reg = v;
      `FDSI_OFS_CFG: cfg = v;
      `FDSI_OFS_CCR, `FDSI_OFS_DSR: rate = v[1:0];
      `FDSI_OFS_OPCTL: op = v[3:0];
      default: ;
    endcase
    @(posedge MCLK);
    #1;
    chk("pins", exp_pins(), pin);
  endtask
  task automatic hit_reset(input int n);
    RST <= 1'b1;
    repeat (n) @(posedge MCLK);
    RST <= 1'b0;
    {digital_output_reg, cfg, op, rate} = '0;
    @(posedge MCLK);
    #1;
    chk("rst_pins", exp_pins(), pin);
  endtask
  initial begin
    {MCLK, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    RST = 1'b1;
    {failures, comparisons, cyc} = '0;
    void'($urandom(32'h9fc7));
    // Reset is high from time zero, so the first edge counts too
    @(posedge MCLK);
    hit_reset(15);
    foreach (ra[i]) rd(ra[i], 32'h0, "reset_val");
    for (int i = 0; i < 16; i++) begin
      step(`FDSI_OFS_CFG, {i[3], 1'b0, i[2], 5'h0});
      step(i[0] ? `FDSI_OFS_DSR : `FDSI_OFS_CCR, {6'h0, ~i[1:0]});
      step(i[0] ? `FDSI_OFS_CCR : `FDSI_OFS_DSR, {6'h0, i[1:0]});
      step(`FDSI_OFS_OPCTL, {4'h0, i[3:0]});
      step(`FDSI_OFS_DOR, {i[3:0], 2'h0, i[1:0]});
    end
    repeat (60) step(wa[$urandom % 5], 8'($urandom));
    dm.set_change(1'b1);
    repeat (4) @(posedge MCLK);
    rd(`FDSI_OFS_DIN, 32'h80, "din_chg");
    step(`FDSI_OFS_MODE, 8'h01);
    rd(`FDSI_OFS_DIN, 32'h00, "din_gate");
    rd(`FDSI_OFS_STATUS, {29'h0, op[1:0], 1'b1}, "status");
    step(`FDSI_OFS_MODE, 8'h00);
    dm.set_change(1'b0);
    dm.pulse_index(3);
    rd(`FDSI_OFS_IDXCNT, 32'h3, "idx_cnt");
    step(`FDSI_OFS_IDXCNT, 8'h00);
    rd(`FDSI_OFS_IDXCNT, 32'h0, "idx_clr");
    step(`FDSI_OFS_DIN, 8'hff);
    rd(`FDSI_OFS_DIN, 32'h00, "din_ro");
    foreach (ra[i]) begin
      apb(1'b0, ra[i] + 8'h24, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, e});
      chk("unmapped_data", 32'h0, r);
    end
    hit_reset(2);
    end_sim();
  end
endmodule
